/* File: src/cbap_pkg.sv */
package cbap_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W      = 32;
  localparam int ADDR_HI     = 31;
  localparam int ADDR_LO     = 3;
  localparam int PAR_LO      = 5;
  localparam int MASK_BIT    = 20;
  localparam int BUS_W       = ADDR_HI - ADDR_LO + 1;
  localparam int SNOOP_W     = ADDR_HI - PAR_LO + 1;
  localparam int PAR_OFS     = PAR_LO - ADDR_LO;
  localparam int MASK_OFS    = MASK_BIT - ADDR_LO;
  localparam int CDEF_W      = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [BUS_W-1:0]  BUS_RST  = '0;
  localparam logic [CDEF_W-1:0] CDEF_RST = '0;

  // ----------------------------------------
  // cycle kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    CBAP_CYC_MEM,
    CBAP_CYC_IO,
    CBAP_CYC_SPECIAL
  } cbap_cyc_t;

  // even parity bit over the covered address lines
  function automatic logic cbap_even_par(input logic [BUS_W-1:0] bus);
    cbap_even_par = ^bus[BUS_W-1:PAR_OFS];
  endfunction
endpackage : cbap_pkg

/* File: src/cbap_if.sv */
interface cbap_if;
  import cbap_pkg::*;
  // address lines 31:3, bit 0 is line 3 (line 5 on the sys_ vectors, which cover 31:5)
  logic [BUS_W-1:0]  dev_addr_o;
  logic [BUS_W-1:0]  dev_addr_oe_n;
  logic [SNOOP_W-1:0] sys_addr_o;
  logic [SNOOP_W-1:0] sys_addr_oe_n;
  logic              dev_par_o;
  logic              dev_par_oe_n;
  logic              sys_par_o;
  logic              sys_par_oe_n;
  logic [CDEF_W-1:0] cycle_def;
  logic              addr_strobe_n;
  logic              addr_strobe_dup_n;
  logic              addr_hold_req;
  logic              addr_parity_err_n;
  logic              addr_bit20_mask_n;
  // resolved wire levels (pull-down if nobody drives)
  logic [BUS_W-1:0]  addr_bus;
  logic              addr_parity;
  always_comb begin
    for (int i = 0; i < BUS_W; i++) begin
      addr_bus[i] = 1'b0;
      if (!dev_addr_oe_n[i])
        addr_bus[i] = dev_addr_o[i];
      else if (i >= PAR_OFS && !sys_addr_oe_n[i-PAR_OFS])
        addr_bus[i] = sys_addr_o[i-PAR_OFS];
    end
    addr_parity = !dev_par_oe_n ? dev_par_o : (!sys_par_oe_n ? sys_par_o : 1'b0);
  end
  modport device (output dev_addr_o, dev_addr_oe_n, dev_par_o, dev_par_oe_n, cycle_def,
                  addr_strobe_n, addr_strobe_dup_n, addr_parity_err_n,
                  input addr_bus, addr_parity, addr_hold_req, addr_bit20_mask_n);
  modport system (output sys_addr_o, sys_addr_oe_n, sys_par_o, sys_par_oe_n, addr_hold_req,
                  addr_bit20_mask_n,
                  input addr_bus, addr_parity, addr_strobe_n, addr_strobe_dup_n, cycle_def,
                  addr_parity_err_n);
endinterface : cbap_if

/* File: src/cbap_device.sv */
// Operation
// R1: mask clears address bit 20
// R2: address on lines 31:3 for memory/io
// R3: special cycles drive cycle definition on bus
// R4: system drives snoop 31:5, device samples
// R5: strobe low starts each bus cycle
// R6: address, definition valid with strobe
// R7: copy strobe mirrors primary strobe
// R8: system holds address, then drives snoop
// R9: hold sampled floats address and parity
// R10: other outputs stay driven during hold
// R11: parity is even over lines 31:5
// R12: ones on parity plus lines even
// R13: lines 4, 3 excluded from parity
// R14: snoop parity error pulses one clock
// R15: redrive address before next strobe
module cbap_device
  import cbap_pkg::*;
#(
  // address line that the bit-20 mask clears
  parameter int P_MASK_BIT = cbap_pkg::MASK_BIT
)
(
  // clock, reset, enable
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_srst,
  input  wire logic                        i_ce,
  // bus
  cbap_if.device                           bus,
  // user request
  input  wire logic                        i_req,
  input  wire cbap_pkg::cbap_cyc_t         i_kind,
  input  wire logic [cbap_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [cbap_pkg::CDEF_W-1:0] i_cdef,
  // status and inquire result
  output logic                             o_busy,
  output logic                             o_snoop_vld,
  output logic [cbap_pkg::SNOOP_W-1:0]     o_snoop_addr,
  output logic                             o_snoop_par_err
);
  import cbap_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  // the mask must land on a line that the device drives
  if (P_MASK_BIT < ADDR_LO || P_MASK_BIT > ADDR_HI) begin : g_bad_mask_bit
    $error("mask bit outside the address lines");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RESUME} cbap_dst_t;
  localparam int    MASK_IDX = P_MASK_BIT - ADDR_LO;
  cbap_dst_t        state;
  logic [BUS_W-1:0] addr_q;
  logic             par_q;
  logic             hold_q;
  logic             strobe_n;
  logic             perr_n;
  logic             oe_n;
  logic [BUS_W-1:0] next_addr;
  logic             snoop_ok;
  logic             launch;

  always_comb begin
    next_addr = i_addr[ADDR_HI:ADDR_LO];
    // R1: mask bit 20
    if (!bus.addr_bit20_mask_n && i_kind != CBAP_CYC_SPECIAL)
      next_addr[MASK_IDX] = 1'b0;
    // R3: cycle definition on bus
    if (i_kind == CBAP_CYC_SPECIAL) begin
      next_addr = BUS_RST;
      next_addr[CDEF_W-1:0] = i_cdef;
    end
  end

  // inquire lines are trusted only once hold has stood on two edges,
  // the first edge after hold is spent turning the bus around
  assign snoop_ok = hold_q && bus.addr_hold_req;

  // R15: no strobe unless bus is driven
  // a request on the same edge as hold loses, so the float is never late
  assign launch = i_req && state == ST_IDLE && !oe_n && !bus.addr_hold_req;

  // ----------------------------------------
  // address hold tracking
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state  <= ST_IDLE;
      hold_q <= 1'b0;
      oe_n   <= 1'b1;
    end else if (i_ce) begin
      hold_q <= bus.addr_hold_req;
      case (state)
        ST_IDLE: begin
          // R9: float on hold edge
          if (bus.addr_hold_req) begin
            state <= ST_HOLD;
            oe_n  <= 1'b1;
          end else begin
            oe_n <= 1'b0;
          end
        end
        ST_HOLD: begin
          // R15: redrive after hold drops
          if (!bus.addr_hold_req) begin
            state <= ST_RESUME;
            oe_n  <= 1'b0;
          end
        end
        ST_RESUME: begin
          if (bus.addr_hold_req) begin
            state <= ST_HOLD;
            oe_n  <= 1'b1;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // cycle launch
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      strobe_n <= 1'b1;
      addr_q   <= BUS_RST;
      par_q    <= 1'b0;
    end else if (i_ce) begin
      strobe_n <= 1'b1;
      // R5: strobe starts cycle
      // R6: address with strobe
      if (launch) begin
        strobe_n <= 1'b0;
        // R2: physical address
        addr_q   <= next_addr;
        // R11: parity registered with address
        par_q    <= cbap_even_par(next_addr);
      end
    end
  end

  // ----------------------------------------
  // cycle definition
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      bus.cycle_def <= CDEF_RST;
    end else if (i_ce) begin
      // R6: definition with strobe
      if (launch) begin
        bus.cycle_def <= i_cdef;
      end
    end
  end

  // ----------------------------------------
  // busy status
  // ----------------------------------------
  // busy lags the hold pin by one edge; a request raised in that
  // window is simply not taken, so the user must keep it up
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_busy <= bus.addr_hold_req || state != ST_IDLE || oe_n;
    end
  end

  // ----------------------------------------
  // inquire sampling
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      perr_n          <= 1'b1;
      o_snoop_vld     <= 1'b0;
      o_snoop_addr    <= '0;
      o_snoop_par_err <= 1'b0;
    end else if (i_ce) begin
      perr_n          <= 1'b1;
      o_snoop_vld     <= 1'b0;
      o_snoop_par_err <= 1'b0;
      // R4: sample snoop address
      if (snoop_ok && state == ST_HOLD) begin
        o_snoop_vld  <= 1'b1;
        o_snoop_addr <= bus.addr_bus[BUS_W-1:PAR_OFS];
        // R13: lines 4, 3 skipped
        // R14: one-clock error pulse
        if (cbap_even_par(bus.addr_bus) != bus.addr_parity) begin
          perr_n          <= 1'b0;
          o_snoop_par_err <= 1'b1;
        end
      end
    end
  end

  // R10: strobes and error always driven
  // R7: copy strobe identical
  assign bus.addr_strobe_n     = strobe_n;
  assign bus.addr_strobe_dup_n = strobe_n;
  assign bus.addr_parity_err_n = perr_n;
  assign bus.dev_addr_o        = addr_q;
  assign bus.dev_addr_oe_n     = {BUS_W{oe_n}};
  // R11: even parity driven
  // R12: total ones even
  assign bus.dev_par_o         = par_q;
  assign bus.dev_par_oe_n      = oe_n;
endmodule : cbap_device

/* File: src/cbap_system.sv */
module cbap_system
  import cbap_pkg::*;
(
  // clock, reset, enable
  input  wire logic               i_sys_clk,
  input  wire logic               i_srst,
  input  wire logic               i_ce,
  // bus
  cbap_if.system                  bus,
  // user side
  input  wire logic               i_mask_req,
  input  wire logic               i_snoop_req,
  input  wire logic [SNOOP_W-1:0] i_snoop_addr,
  input  wire logic               i_bad_par,
  output logic                    o_snoop_done,
  output logic                    o_cyc_seen,
  output logic [BUS_W-1:0]        o_cyc_addr,
  output logic                    o_par_err_seen
);
  import cbap_pkg::*;

  typedef enum logic [1:0] {SS_IDLE, SS_HOLD, SS_DRIVE, SS_REL} cbap_sst_t;
  cbap_sst_t          state;
  logic               hold;
  logic               drv_n;
  logic [SNOOP_W-1:0] addr_q;
  logic               par_q;
  logic               mask_n;

  // ----------------------------------------
  // inquire sequencing
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state        <= SS_IDLE;
      hold         <= 1'b0;
      drv_n        <= 1'b1;
      addr_q       <= '0;
      par_q        <= 1'b0;
      o_snoop_done <= 1'b0;
    end else if (i_ce) begin
      o_snoop_done <= 1'b0;
      case (state)
        // R8: hold first, address next
        SS_IDLE: if (i_snoop_req) begin
          hold   <= 1'b1;
          addr_q <= i_snoop_addr;
          // R11: even parity, R12: ones even
          par_q  <= (^i_snoop_addr) ^ i_bad_par;
          state  <= SS_HOLD;
        end
        SS_HOLD: begin
          // R4: system drives 31:5
          drv_n <= 1'b0;
          state <= SS_DRIVE;
        end
        SS_DRIVE: begin
          drv_n        <= 1'b1;
          o_snoop_done <= 1'b1;
          state        <= SS_REL;
        end
        SS_REL: begin
          hold  <= 1'b0;
          state <= SS_IDLE;
        end
        default: state <= SS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // observation
  // ----------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mask_n         <= 1'b1;
      o_cyc_seen     <= 1'b0;
      o_cyc_addr     <= BUS_RST;
      o_par_err_seen <= 1'b0;
    end else if (i_ce) begin
      mask_n         <= !i_mask_req;
      o_cyc_seen     <= !bus.addr_strobe_n;
      o_par_err_seen <= !bus.addr_parity_err_n;
      if (!bus.addr_strobe_n)
        o_cyc_addr <= bus.addr_bus;
    end
  end

  assign bus.addr_hold_req     = hold;
  assign bus.addr_bit20_mask_n = mask_n;
  assign bus.sys_addr_o        = addr_q;
  assign bus.sys_addr_oe_n     = {SNOOP_W{drv_n}};
  assign bus.sys_par_o         = par_q;
  assign bus.sys_par_oe_n      = drv_n;
endmodule : cbap_system

/* File: verif/cbap_checker.sv */
module cbap_checker
  import cbap_pkg::*;
(
  // clock, reset
  input wire logic                       i_sys_clk,
  input wire logic                       i_srst,
  // bus wires
  input wire logic [cbap_pkg::BUS_W-1:0] dev_addr_oe_n,
  input wire logic                       dev_par_oe_n,
  input wire logic [cbap_pkg::BUS_W-1:0] addr_bus,
  input wire logic                       addr_parity,
  input wire logic                       addr_strobe_n,
  input wire logic                       addr_strobe_dup_n,
  input wire logic                       addr_hold_req,
  input wire logic                       addr_parity_err_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ----
  // bus ownership
  // ----
  sequence s_float;
    (&dev_addr_oe_n) && dev_par_oe_n;
  endsequence
  sequence s_drive;
    (dev_addr_oe_n == '0) && !dev_par_oe_n;
  endsequence

  dup_strobe_a: assert property (addr_strobe_dup_n == addr_strobe_n)
    else $error("copy strobe differs");
  strobe_drive_a: assert property (!addr_strobe_n |-> s_drive)
    else $error("strobe without address");
  strobe_nohold_a: assert property (!addr_strobe_n |-> !$past(addr_hold_req))
    else $error("strobe after hold");
  hold_float_a: assert property (addr_hold_req |=> s_float)
    else $error("address not floated");
  par_even_a: assert property (s_drive |-> !(^{addr_parity, addr_bus[BUS_W-1:PAR_OFS]}))
    else $error("odd address parity");
  err_pulse_a: assert property ($fell(addr_parity_err_n) |=> addr_parity_err_n)
    else $error("parity error too long");
  err_inquire_a: assert property (!addr_parity_err_n |-> $past(addr_hold_req))
    else $error("parity error outside inquire");
  err_cause_a: assert property ($fell(addr_parity_err_n) |-> ^{$past(addr_parity), ($past(addr_bus) >> PAR_OFS)})
    else $error("parity error without cause");
  resume_a: assert property ($fell(addr_hold_req) |-> ##[1:3] s_drive)
    else $error("address not redriven");
endmodule // cbap_checker

/* File: verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cbap_pkg::*;
  logic               i_sys_clk = 1'b0;
  logic               i_srst = 1'b1;
  logic               i_req = 1'b0;
  logic               i_mask_req = 1'b0;
  logic               i_snoop_req = 1'b0;
  logic               i_bad_par = 1'b0;
  cbap_cyc_t          i_kind = CBAP_CYC_MEM;
  logic [31:0]        i_addr = '0;
  logic [31:0]        seed = 32'hCF74064E;
  logic [3:0]         i_cdef = '0;
  logic [SNOOP_W-1:0] i_snoop_addr = '0;
  logic               o_busy, o_snoop_vld, o_snoop_par_err, o_snoop_done, o_cyc_seen, o_par_err_seen;
  logic [SNOOP_W-1:0] o_snoop_addr;
  logic [BUS_W-1:0]   o_cyc_addr;
  int                 bad_count = 0;
  int                 check_count = 0;

  cbap_if i_cbap_if ();
  cbap_device i_cbap_device (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(1'b1), .bus(i_cbap_if),
    .i_req(i_req), .i_kind(i_kind), .i_addr(i_addr), .i_cdef(i_cdef), .o_busy(o_busy),
    .o_snoop_vld(o_snoop_vld), .o_snoop_addr(o_snoop_addr), .o_snoop_par_err(o_snoop_par_err));
  cbap_system i_cbap_system (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ce(1'b1), .bus(i_cbap_if),
    .i_mask_req(i_mask_req), .i_snoop_req(i_snoop_req), .i_snoop_addr(i_snoop_addr),
    .i_bad_par(i_bad_par), .o_snoop_done(o_snoop_done), .o_cyc_seen(o_cyc_seen),
    .o_cyc_addr(o_cyc_addr), .o_par_err_seen(o_par_err_seen));
  cbap_checker u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .dev_addr_oe_n(i_cbap_if.dev_addr_oe_n), .dev_par_oe_n(i_cbap_if.dev_par_oe_n),
    .addr_bus(i_cbap_if.addr_bus), .addr_parity(i_cbap_if.addr_parity),
    .addr_strobe_n(i_cbap_if.addr_strobe_n), .addr_strobe_dup_n(i_cbap_if.addr_strobe_dup_n),
    .addr_hold_req(i_cbap_if.addr_hold_req), .addr_parity_err_n(i_cbap_if.addr_parity_err_n));

  initial forever #10 i_sys_clk = ~i_sys_clk;

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // masking applies to memory and io only; special cycles carry the definition
  function automatic logic [BUS_W-1:0] exp_bus(cbap_cyc_t k, logic [31:0] a, logic [3:0] c, logic m);
    logic [BUS_W-1:0] b;
    b = a[31:3];
    if (m)
      b[MASK_OFS] = 1'b0;
    if (k == CBAP_CYC_SPECIAL)
      b = {{(BUS_W-4){1'b0}}, c};
    return b;
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic tick;
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic wait_lvl(ref logic s, input logic lvl);
    for (int n = 0; n < 20 && s !== lvl; n++)
      tick();
    if (s !== lvl) begin
      bad_count++;
      $display("BAD %0t wait timed out", $time);
      give_verdict();
    end
  endtask

  task automatic do_cyc(cbap_cyc_t k, logic [31:0] a, logic [3:0] c, logic m);
    i_mask_req = m;
    i_kind = k;
    i_addr = a;
    i_cdef = c;
    tick();
    tick();
    wait_lvl(o_busy, 1'b0);
    i_req = 1'b1;
    tick();
    i_req = 1'b0;
    wait_lvl(i_cbap_if.addr_strobe_n, 1'b0);
    chk(i_cbap_if.addr_bus === exp_bus(k, a, c, m), "cycle address");
    chk(i_cbap_if.cycle_def === c, "cycle definition");
    tick();
    chk(o_cyc_seen === 1'b1 && o_cyc_addr === exp_bus(k, a, c, m), "system view");
  endtask

  task automatic do_snoop(logic [SNOOP_W-1:0] a, logic bad);
    i_snoop_addr = a;
    i_bad_par = bad;
    i_snoop_req = 1'b1;
    tick();
    i_snoop_req = 1'b0;
    wait_lvl(o_snoop_vld, 1'b1);
    chk(o_snoop_addr === a && o_snoop_par_err === bad, "inquire sample");
    chk(i_cbap_if.addr_parity_err_n === !bad, "parity error pin");
    chk(o_snoop_done === 1'b1, "inquire done");
    tick();
    chk(o_par_err_seen === bad && i_cbap_if.addr_parity_err_n === 1'b1, "error pulse length");
    wait_lvl(o_busy, 1'b0);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge i_sys_clk);
    #1 i_srst = 1'b0;
    tick();
    do_cyc(CBAP_CYC_MEM, 32'hFFFFFFFF, 4'h0, 1'b1);
    do_cyc(CBAP_CYC_IO, 32'hFFFFFFFF, 4'h0, 1'b0);
    do_cyc(CBAP_CYC_SPECIAL, 32'h12345678, 4'hF, 1'b1);
    do_snoop('1, 1'b1);
    do_snoop('0, 1'b0);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      if (seed[4])
        do_snoop(seed[31:5], seed[3]);
      else
        do_cyc(seed[1:0] == 2'h3 ? CBAP_CYC_MEM : cbap_cyc_t'(seed[1:0]), lfsr(seed), seed[8:5], seed[2]);
    end
    give_verdict();
  end
endmodule // tb_top
